// ===== shared/hsbuf_cfg.svh
// Timing counts, bit positions and reset values of the hot-swap bus buffer
`ifndef HSBUF_CFG_SVH
`define HSBUF_CFG_SVH

`define HSBUF_CLK_NS 50
`define HSBUF_SYNC_STAGES 2
// Bit positions in the synchroniser word
`define HSBUF_BIT_BP_DATA 0
`define HSBUF_BIT_BP_CLK 1
`define HSBUF_BIT_CARD_DATA 2
`define HSBUF_BIT_CARD_CLK 3
`define HSBUF_BIT_EN 4
// Lines idle high, enable low
`define HSBUF_SYNC_RST 5'h0F

`define HSBUF_STUCK_MS 30
`define HSBUF_STUCK_CYC ((`HSBUF_STUCK_MS * 1000000) / `HSBUF_CLK_NS)
`define HSBUF_IDLE_US 95
`define HSBUF_IDLE_CYC ((`HSBUF_IDLE_US * 1000 + `HSBUF_CLK_NS - 1) / `HSBUF_CLK_NS)
`define HSBUF_GAP_US 40
`define HSBUF_GAP_CYC ((`HSBUF_GAP_US * 1000 + `HSBUF_CLK_NS - 1) / `HSBUF_CLK_NS)
`define HSBUF_REC_HZ 8500
`define HSBUF_REC_HALF_CYC ((1000000000 / (2 * `HSBUF_REC_HZ)) / `HSBUF_CLK_NS)
`define HSBUF_REC_PULSES 16
`define HSBUF_EN_OFF_NS 300
`define HSBUF_EN_OFF_CYC ((`HSBUF_EN_OFF_NS / `HSBUF_CLK_NS) - `HSBUF_SYNC_STAGES)
`define HSBUF_GUARD_NS 500
`define HSBUF_GUARD_CYC (`HSBUF_GUARD_NS / `HSBUF_CLK_NS)

`endif

// ===== shared/hsbuf_pkg.sv
// Types of the hot-swap bus buffer
`default_nettype none
package hsbuf_pkg;
  typedef enum logic [1:0] {
    HSBUF_WAIT = 2'h0,
    HSBUF_CONN = 2'h1,
    HSBUF_GAP = 2'h3,
    HSBUF_RECOV = 2'h2
  } hsbuf_state_t;
endpackage : hsbuf_pkg
`default_nettype wire

// ===== shared/hsbuf_sync_if.sv
// Raw and synchronised pin word between the buffer core and its synchroniser
`default_nettype none
interface hsbuf_sync_if;
  logic [4:0] raw;
  logic [4:0] sync;
  modport sync_side (input raw, output sync);
  modport user_side (output raw, input sync);
endinterface : hsbuf_sync_if
`default_nettype wire

// ===== design/hsbuf_sync.sv
// Two-stage synchroniser for the bus lines and the enable pin
`include "hsbuf_cfg.svh"
`default_nettype none
module hsbuf_sync (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  hsbuf_sync_if.sync_side port
);
  logic [4:0] stage1;
  logic [4:0] stage2;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1 <= `HSBUF_SYNC_RST;
      stage2 <= `HSBUF_SYNC_RST;
    end else begin
      stage1 <= port.raw;
      stage2 <= stage1;
    end
  end

  assign port.sync = stage2;

  AST_SYNC_LATENCY: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    ##2 port.sync == $past(port.raw, 2))
    else $error("synchronised word does not follow pins two cycles late");
endmodule : hsbuf_sync
`default_nettype wire

// ===== design/hsbuf_top.sv
// Hot-swap two-wire bus buffer: connection control, stuck-bus timeout and recovery
`include "hsbuf_cfg.svh"
`default_nettype none
module hsbuf_top #(
  parameter int unsigned STUCK_CYC = `HSBUF_STUCK_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic backplane_data_line_in,
  output logic backplane_data_line_out,
  output logic backplane_data_line_oe_out,
  input wire logic backplane_clock_line_in,
  output logic backplane_clock_line_out,
  output logic backplane_clock_line_oe_out,
  input wire logic card_data_line_in,
  output logic card_data_line_out,
  output logic card_data_line_oe_out,
  input wire logic card_clock_line_in,
  output logic card_clock_line_out,
  output logic card_clock_line_oe_out,
  output logic ready_out,
  output logic ready_oe_out
);
  hsbuf_sync_if sif ();
  assign sif.raw = {enable_in, card_clock_line_in, card_data_line_in,
                    backplane_clock_line_in, backplane_data_line_in};
  hsbuf_sync u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .port(sif.sync_side)
  );

  logic bp_data, bp_clk, en_s, cards_high;
  logic [1:0] bp_low, card_low;
  assign bp_data = sif.sync[`HSBUF_BIT_BP_DATA];
  assign bp_clk = sif.sync[`HSBUF_BIT_BP_CLK];
  assign en_s = sif.sync[`HSBUF_BIT_EN];
  assign bp_low = ~sif.sync[`HSBUF_BIT_BP_CLK:`HSBUF_BIT_BP_DATA];
  assign card_low = ~sif.sync[`HSBUF_BIT_CARD_CLK:`HSBUF_BIT_CARD_DATA];
  assign cards_high = (card_low == 2'h0);

  hsbuf_pkg::hsbuf_state_t state, next_state;
  logic conn, next_conn;
  assign conn = (state == hsbuf_pkg::HSBUF_CONN);
  // Pass-through drive follows the state being entered, so it drops on the cutting edge
  assign next_conn = (next_state == hsbuf_pkg::HSBUF_CONN);

  // Line monitor: stop/idle qualification and the stuck timer
  logic bp_data_q, bp_clk_q, en_q, bp_done, next_bp_done;
  logic [10:0] idle_cnt, next_idle_cnt;
  logic [19:0] stuck_cnt, next_stuck_cnt;
  logic stop_seen, start_seen, idle_ok, stuck_hit;
  assign stop_seen = bp_clk && bp_clk_q && bp_data && !bp_data_q;
  assign start_seen = bp_clk && bp_clk_q && !bp_data && bp_data_q;
  assign idle_ok = (idle_cnt == 11'(`HSBUF_IDLE_CYC));
  assign stuck_hit = (stuck_cnt == 20'(STUCK_CYC));
  always_comb begin
    next_idle_cnt = idle_cnt;
    if (bp_low != 2'h0) begin
      next_idle_cnt = 11'h000;
    end else if (!idle_ok) begin
      next_idle_cnt = idle_cnt + 11'h001;
    end
    next_bp_done = bp_done;
    if (start_seen) begin
      next_bp_done = 1'h0;
    end else if (stop_seen || idle_ok) begin
      next_bp_done = 1'h1;
    end
    next_stuck_cnt = stuck_cnt;
    if (cards_high || state == hsbuf_pkg::HSBUF_GAP || state == hsbuf_pkg::HSBUF_RECOV) begin
      next_stuck_cnt = 20'h00000;
    end else if (!stuck_hit) begin
      next_stuck_cnt = stuck_cnt + 20'h00001;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bp_data_q <= 1'h1;
      bp_clk_q <= 1'h1;
      en_q <= 1'h0;
      bp_done <= 1'h0;
      idle_cnt <= 11'h000;
      stuck_cnt <= 20'h00000;
    end else begin
      bp_data_q <= bp_data;
      bp_clk_q <= bp_clk;
      en_q <= en_s;
      bp_done <= next_bp_done;
      idle_cnt <= next_idle_cnt;
      stuck_cnt <= next_stuck_cnt;
    end
  end

  // Connection controller
  logic fault, next_fault, rec_low, next_rec_low;
  logic [10:0] div_cnt, next_div_cnt;
  logic [4:0] pulse_cnt, next_pulse_cnt;
  logic [2:0] off_cnt, next_off_cnt;
  always_comb begin
    next_state = state;
    next_fault = fault;
    next_rec_low = rec_low;
    next_div_cnt = div_cnt;
    next_pulse_cnt = pulse_cnt;
    next_off_cnt = 3'h0;
    case (state)
      hsbuf_pkg::HSBUF_WAIT: begin
        // A forced join still leaves the stuck timer running, so a dead card faults again
        if (en_s && ((fault && !en_q) || (bp_done && cards_high))) begin
          next_state = hsbuf_pkg::HSBUF_CONN;
          next_fault = 1'h0;
        end else if (stuck_hit) begin
          next_fault = 1'h1;
          if (en_s) begin
            next_state = hsbuf_pkg::HSBUF_GAP;
            next_div_cnt = 11'h000;
          end
        end
      end
      hsbuf_pkg::HSBUF_CONN: begin
        if (!en_s) begin
          next_off_cnt = off_cnt + 3'h1;
          if (off_cnt == 3'(`HSBUF_EN_OFF_CYC - 1)) begin
            next_state = hsbuf_pkg::HSBUF_WAIT;
          end
        end else if (stuck_hit) begin
          next_state = hsbuf_pkg::HSBUF_GAP;
          next_fault = 1'h1;
          next_div_cnt = 11'h000;
        end
      end
      hsbuf_pkg::HSBUF_GAP: begin
        if (!en_s) begin
          next_state = hsbuf_pkg::HSBUF_WAIT;
        end else if (div_cnt == 11'(`HSBUF_GAP_CYC - 1)) begin
          next_state = hsbuf_pkg::HSBUF_RECOV;
          next_div_cnt = 11'h000;
          next_pulse_cnt = 5'h00;
          next_rec_low = 1'h0;
        end else begin
          next_div_cnt = div_cnt + 11'h001;
        end
      end
      hsbuf_pkg::HSBUF_RECOV: begin
        if (!en_s) begin
          next_state = hsbuf_pkg::HSBUF_WAIT;
          next_rec_low = 1'h0;
        end else if (div_cnt == 11'(`HSBUF_REC_HALF_CYC - 1)) begin
          next_div_cnt = 11'h000;
          if (rec_low) begin
            next_rec_low = 1'h0;
            next_pulse_cnt = pulse_cnt + 5'h01;
          end else if (pulse_cnt == 5'(`HSBUF_REC_PULSES) || cards_high) begin
            next_state = hsbuf_pkg::HSBUF_WAIT;
          end else begin
            next_rec_low = 1'h1;
          end
        end else begin
          next_div_cnt = div_cnt + 11'h001;
        end
      end
      default: begin
        next_state = hsbuf_pkg::HSBUF_WAIT;
        next_rec_low = 1'h0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= hsbuf_pkg::HSBUF_WAIT;
      fault <= 1'h0;
      rec_low <= 1'h0;
      div_cnt <= 11'h000;
      pulse_cnt <= 5'h00;
      off_cnt <= 3'h0;
    end else begin
      state <= next_state;
      fault <= next_fault;
      rec_low <= next_rec_low;
      div_cnt <= next_div_cnt;
      pulse_cnt <= next_pulse_cnt;
      off_cnt <= next_off_cnt;
    end
  end

  // Pass-through: index 0 is the data pair, 1 the clock pair.
  // The guard masks our own echo while a released line rises through the synchroniser;
  // it assumes rise plus sync fits well inside a 400 kHz low phase.
  logic [1:0] drv_bp, next_drv_bp, drv_card, next_drv_card;
  logic [3:0] guard [0:1];
  logic [3:0] next_guard [0:1];
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_drv_bp[i] = drv_bp[i];
      next_drv_card[i] = drv_card[i];
      next_guard[i] = guard[i];
      if (!next_conn) begin
        next_drv_bp[i] = 1'h0;
        next_drv_card[i] = 1'h0;
        next_guard[i] = 4'h0;
      end else if (drv_bp[i]) begin
        if (!card_low[i]) begin
          next_drv_bp[i] = 1'h0;
          next_guard[i] = 4'(`HSBUF_GUARD_CYC);
        end
      end else if (drv_card[i]) begin
        if (!bp_low[i]) begin
          next_drv_card[i] = 1'h0;
          next_guard[i] = 4'(`HSBUF_GUARD_CYC);
        end
      end else if (guard[i] != 4'h0) begin
        next_guard[i] = guard[i] - 4'h1;
      end else if (card_low[i]) begin
        next_drv_bp[i] = 1'h1;
      end else if (bp_low[i]) begin
        next_drv_card[i] = 1'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drv_bp <= 2'h0;
      drv_card <= 2'h0;
      guard[0] <= 4'h0;
      guard[1] <= 4'h0;
    end else begin
      drv_bp <= next_drv_bp;
      drv_card <= next_drv_card;
      guard[0] <= next_guard[0];
      guard[1] <= next_guard[1];
    end
  end

  assign backplane_data_line_out = 1'h0;
  assign backplane_clock_line_out = 1'h0;
  assign card_data_line_out = 1'h0;
  assign card_clock_line_out = 1'h0;
  assign ready_out = 1'h0;
  assign backplane_data_line_oe_out = drv_bp[0];
  assign backplane_clock_line_oe_out = drv_bp[1];
  assign card_data_line_oe_out = drv_card[0];
  assign card_clock_line_oe_out = drv_card[1] | rec_low;
  assign ready_oe_out = !conn;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_TIMEOUT_BREAKS: assert property (
    conn && en_s && stuck_hit |=> state == hsbuf_pkg::HSBUF_GAP && backplane_data_line_oe_out == 1'h0
      ##0 ready_oe_out)
    else $error("stuck timeout did not break the connection");
  AST_PULSE_LIMIT: assert property (
    pulse_cnt <= 5'h10 && !(rec_low && pulse_cnt == 5'h10))
    else $error("more than sixteen recovery pulses");
  AST_RECONNECT: assert property (
    state == hsbuf_pkg::HSBUF_WAIT && en_s && bp_done && cards_high |=> conn)
    else $error("free bus not reconnected");
  AST_JOIN_QUALIFIED: assert property (
    $rose(conn) |-> $past(en_s) && ($past(bp_done) || ($past(fault) && !$past(en_q))))
    else $error("connection made without stop, idle or forced enable");
  AST_ISOLATED: assert property (
    !conn |-> !backplane_data_line_oe_out && !backplane_clock_line_oe_out
      && !card_data_line_oe_out && card_clock_line_oe_out == rec_low)
    else $error("pass-through drive while isolated");
  AST_READY_LEVEL: assert property (
    $changed(state) |-> ready_oe_out == (state != hsbuf_pkg::HSBUF_CONN))
    else $error("ready does not follow the connection");
  AST_ENABLE_OFF: assert property (
    !en_s [*5] |-> !conn)
    else $error("enable low did not disconnect in time");
  AST_WIRED_AND: assert property (
    conn && next_conn && card_low[0] && !drv_card[0] && !drv_bp[0] && guard[0] == 4'h0
      |=> backplane_data_line_oe_out)
    else $error("card low not passed to backplane");
  AST_STUCK_CLEAR: assert property (
    cards_high |=> stuck_cnt == 20'h00000)
    else $error("stuck timer not cleared with both lines high");
  AST_GAP_LENGTH: assert property (
    $rose(state == hsbuf_pkg::HSBUF_RECOV) |-> $past(div_cnt) == 11'(`HSBUF_GAP_CYC - 1))
    else $error("recovery began before the gap elapsed");
  AST_ENABLE_SUPPRESS: assert property (
    !en_s && (state == hsbuf_pkg::HSBUF_GAP || state == hsbuf_pkg::HSBUF_RECOV)
      |=> state == hsbuf_pkg::HSBUF_WAIT ##0 !rec_low)
    else $error("recovery clocking with enable low");

  COV_CONNECT: cover property ($rose(conn));
  COV_TIMEOUT: cover property (conn ##1 state == hsbuf_pkg::HSBUF_GAP);
  COV_FULL_RECOVERY: cover property (pulse_cnt == 5'h10);
  COV_FORCED_JOIN: cover property (fault && en_s && !en_q && state == hsbuf_pkg::HSBUF_WAIT);
endmodule : hsbuf_top
`default_nettype wire

// ===== test/hsbuf_bus_model.sv
// Open-drain wires of both bus sides, their pull-ups and the ready pull-up
`default_nettype none
module hsbuf_bus_model (
  input wire logic bp_data_pull_in,
  input wire logic bp_clock_pull_in,
  input wire logic card_data_pull_in,
  input wire logic card_clock_pull_in,
  input wire logic [4:0] dut_oe_in,
  output logic bp_data_out,
  output logic bp_clock_out,
  output logic card_data_out,
  output logic card_clock_out,
  output logic ready_out
);
  // A released wire goes to its pull-up level; stimulus clocks stay at or below 400 kHz
  assign bp_data_out = !(bp_data_pull_in || dut_oe_in[0]);
  assign bp_clock_out = !(bp_clock_pull_in || dut_oe_in[1]);
  assign card_data_out = !(card_data_pull_in || dut_oe_in[2]);
  assign card_clock_out = !(card_clock_pull_in || dut_oe_in[3]);
  assign ready_out = !dut_oe_in[4];
endmodule : hsbuf_bus_model
`default_nettype wire

// ===== test/hsbuf_top_test.sv
// Self-checking bench of the hot-swap bus buffer
`default_nettype none
module hsbuf_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  // Short stuck count keeps the run brief; the other counts are the design's own
  localparam int unsigned STUCK = 2000;
  // Half period of the bus clock in system cycles: 400 kHz
  localparam int HALF = 25;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b0;
  logic bd_p = 1'b0;
  logic bc_p = 1'b0;
  logic cd_p = 1'b0;
  logic cc_p = 1'b0;
  logic bd, bc, cd, cc, rdy;
  wire [4:0] oe;
  wire [4:0] lvl;
  int fails = 0;
  int tests_run = 0;
  int n;

  hsbuf_top #(.STUCK_CYC(STUCK)) dut (
    .sys_clk_in(sys_clk), .rst_n_in(rst_n), .enable_in(en),
    .backplane_data_line_in(bd), .backplane_data_line_out(lvl[0]),
    .backplane_data_line_oe_out(oe[0]),
    .backplane_clock_line_in(bc), .backplane_clock_line_out(lvl[1]),
    .backplane_clock_line_oe_out(oe[1]),
    .card_data_line_in(cd), .card_data_line_out(lvl[2]), .card_data_line_oe_out(oe[2]),
    .card_clock_line_in(cc), .card_clock_line_out(lvl[3]), .card_clock_line_oe_out(oe[3]),
    .ready_out(lvl[4]), .ready_oe_out(oe[4]));

  hsbuf_bus_model bus (
    .bp_data_pull_in(bd_p), .bp_clock_pull_in(bc_p), .card_data_pull_in(cd_p),
    .card_clock_pull_in(cc_p), .dut_oe_in(oe), .bp_data_out(bd), .bp_clock_out(bc),
    .card_data_out(cd), .card_clock_out(cc), .ready_out(rdy));

  always #25 sys_clk = ~sys_clk;

  task automatic step(input int cnt);
    repeat (cnt) @(posedge sys_clk);
    #5;
  endtask : step

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Bounded wait for the ready wire to reach a level
  task automatic wait_rdy(input logic lvl, input int limit);
    n = 0;
    while (rdy !== lvl && n < limit) begin
      step(1);
      n++;
    end
  endtask : wait_rdy

  task automatic t_connect();
    check("ready_idle", rdy, 1'b0);
    check("drive_levels", lvl, 16'h0000);
    en = 1'b1;
    wait_rdy(1'b1, 3600);
    check("connect_time", n <= 3500, 1'b1);
    check("ready_joined", rdy, 1'b1);
    $display("test connect done");
  endtask : t_connect

  task automatic t_pass();
    cd_p = 1'b1;
    step(4);
    check("bp_data_low", bd, 1'b0);
    cd_p = 1'b0;
    step(4);
    check("bp_data_high", bd, 1'b1);
    for (int i = 0; i < 4; i++) begin
      bc_p = !bc_p;
      step(4);
      check("card_clk", cc, !bc_p);
      step(HALF - 4);
    end
    $display("test pass_through done");
  endtask : t_pass

  task automatic t_disable();
    en = 1'b0;
    step(5);
    check("ready_hold", rdy, 1'b1);
    step(1);
    check("ready_drop", rdy, 1'b0);
    bd_p = 1'b1;
    step(4);
    check("card_isolated", cd, 1'b1);
    bd_p = 1'b0;
    cc_p = 1'b1;
    step(4);
    check("bp_isolated", bc, 1'b1);
    cc_p = 1'b0;
    step(20);
    $display("test disable done");
  endtask : t_disable

  task automatic t_start_stop();
    bd_p = 1'b1;
    step(5);
    en = 1'b1;
    for (int i = 0; i < 80; i++) begin
      bc_p = !bc_p;
      step(HALF);
    end
    check("no_join_busy", rdy, 1'b0);
    bd_p = 1'b0;
    wait_rdy(1'b1, 20);
    check("join_on_stop", rdy, 1'b1);
    $display("test start_stop done");
  endtask : t_start_stop

  task automatic t_stuck();
    int p;
    int h;
    p = 0;
    cc_p = 1'b1;
    step(1200);
    cd_p = 1'b1;
    cc_p = 1'b0;
    step(STUCK - 1250);
    check("still_joined", rdy, 1'b1);
    wait_rdy(1'b0, 200);
    check("stuck_cut", rdy, 1'b0);
    check("pass_off", oe[0], 1'b0);
    n = 0;
    // The first half-period is released, so a bus that freed itself is seen before any pulse
    while (oe[3] !== 1'b1 && n < 2500) begin
      step(1);
      n++;
    end
    check("gap_len", n >= 800, 1'b1);
    // One spare round must find no seventeenth pulse
    for (int i = 0; i < 17; i++) begin
      h = 0;
      while (oe[3] === 1'b1) begin
        step(1);
        h++;
      end
      if (h > 0) p++;
      if (i == 0) check("half_len", h, 16'd1176);
      h = 0;
      while (oe[3] !== 1'b1 && h < 1300) begin
        step(1);
        h++;
      end
    end
    check("pulses", p, 16'd16);
    check("no_join_stuck", rdy, 1'b0);
    $display("test stuck done");
  endtask : t_stuck

  task automatic t_forced();
    en = 1'b0;
    step(10);
    en = 1'b1;
    wait_rdy(1'b1, 20);
    check("forced_join", rdy, 1'b1);
    $display("test forced done");
  endtask : t_forced

  task automatic t_recover();
    wait_rdy(1'b0, 2200);
    check("stuck_again", rdy, 1'b0);
    cd_p = 1'b0;
    wait_rdy(1'b1, 4000);
    check("auto_join", rdy, 1'b1);
    $display("test recover done");
  endtask : t_recover

  task automatic t_suppress();
    int h;
    h = 0;
    cd_p = 1'b1;
    wait_rdy(1'b0, 2200);
    // Drop enable just after a recovery pulse begins
    n = 0;
    while (oe[3] !== 1'b1 && n < 2500) begin
      step(1);
      n++;
    end
    check("recovery_began", oe[3], 1'b1);
    en = 1'b0;
    step(4);
    for (int i = 0; i < 2400; i++) begin
      step(1);
      if (oe[3] !== 1'b0) h++;
    end
    check("no_clocking", h, 16'd0);
    cd_p = 1'b0;
    $display("test suppress done");
  endtask : t_suppress

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    step(4);
    rst_n = 1'b1;
    t_connect();
    t_pass();
    t_disable();
    t_start_stop();
    t_stuck();
    t_forced();
    t_recover();
    t_suppress();
    print_verdict();
  end

  // Whole sequence needs about 60000 cycles
  initial begin
    #(90000 * 50);
    fails++;
    print_verdict();
  end
endmodule : hsbuf_top_test
`default_nettype wire
